// *** logic/nvl_latch_bank.sv ***
// Purpose: Bank of non-volatile set/reset latches for the logic engine
// Assumes: Operands, selections and types come from same-clock logic;
//          the storage port answers each write with one ack pulse
// Notes:   Latches stay at reset value until storage has been restored
//
// Function
// - Sixteen latches, each with own settings
// - Latch state survives reboot via storage
// - Both asserted: type decides on or off
// - Set only: latch turns on
// - Reset only: latch turns off
`include "nvl_consts.svh"

module nvl_latch_bank #(
  parameter int NUM_LATCHES = `NVL_NUM_LATCHES,
  parameter int NUM_OPERANDS = `NVL_NUM_OPERANDS,
  parameter int SEL_W = $clog2(`NVL_NUM_OPERANDS)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Operand vector and evaluation scan strobe
  input wire logic [NUM_OPERANDS-1:0] operand_i,
  input wire logic eval_i,
  // Per-latch settings
  input wire logic [NUM_LATCHES-1:0] latch_type_i,
  input wire logic [NUM_LATCHES*SEL_W-1:0] set_sel_i,
  input wire logic [NUM_LATCHES*SEL_W-1:0] reset_sel_i,
  // Non-volatile storage port
  input wire logic restore_valid_i,
  input wire logic [NUM_LATCHES-1:0] restore_data_i,
  input wire logic nv_ack_i,
  output logic nv_wr_o,
  output logic [NUM_LATCHES-1:0] nv_wr_data_o,
  // Latch outputs back to the logic engine
  output logic ready_o,
  output logic [NUM_LATCHES-1:0] latch_on_o,
  output logic [NUM_LATCHES-1:0] latch_off_o
);

  // =====================================================================
  // Elaboration checks: refuse sizes the packed state or the selector width cannot hold
  if (NUM_LATCHES != `NVL_NUM_LATCHES) begin : g_bad_latch_count
    $error("Latch count must match the packed state width");
  end
  if (NUM_OPERANDS < 2 || (NUM_OPERANDS > (1 << SEL_W))) begin : g_bad_operand_count
    $error("Operand count does not fit the selector width");
  end

  nvl_pkg::nvl_state_s state;
  nvl_pkg::nvl_state_s next_state;
  logic [NUM_LATCHES-1:0] set_op;
  logic [NUM_LATCHES-1:0] reset_op;
  logic [NUM_LATCHES-1:0] eval_next;

  // =====================================================================
  // Operand selection and per-latch evaluation
  for (genvar i = 0; i < NUM_LATCHES; i++) begin : g_latch
    // Pick the set and reset operands of this latch
    assign set_op[i] = operand_i[set_sel_i[i*SEL_W +: SEL_W]];
    assign reset_op[i] = operand_i[reset_sel_i[i*SEL_W +: SEL_W]];

    nvl_latch_cell u_cell (
      .type_i(latch_type_i[i]),
      .set_i(set_op[i]),
      .reset_i(reset_op[i]),
      .prev_i(state.latch[i]),
      .next_o(eval_next[i])
    );

    // Set alone turns the latch on at the next edge
    AST_SET_ONLY_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state.fsm != nvl_pkg::NVL_WAIT_RESTORE) && eval_i && set_op[i] && !reset_op[i]
      |=> latch_on_o[i] && !latch_off_o[i])
      else $error("Latch did not turn on from set");

    // Reset alone turns the latch off at the next edge
    AST_RESET_ONLY_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state.fsm != nvl_pkg::NVL_WAIT_RESTORE) && eval_i && !set_op[i] && reset_op[i]
      |=> !latch_on_o[i] && latch_off_o[i])
      else $error("Latch did not turn off from reset");

    // Both asserted: dominance type decides
    AST_BOTH_DOMINANCE: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state.fsm != nvl_pkg::NVL_WAIT_RESTORE) && eval_i && set_op[i] && reset_op[i]
      |=> latch_on_o[i] == $past(latch_type_i[i]))
      else $error("Dominance type not honoured");

    // Neither asserted, or no scan: value holds
    AST_HOLD_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state.fsm != nvl_pkg::NVL_WAIT_RESTORE) && !(eval_i && (set_op[i] || reset_op[i]))
      |=> $stable(latch_on_o[i]))
      else $error("Idle latch changed state");
  end

  // =====================================================================
  // Next-state logic of evaluation and storage sequencing
  always_comb begin
    next_state = state;
    unique case (state.fsm)
      nvl_pkg::NVL_WAIT_RESTORE: begin
        // Stored image loads once after boot; scans are ignored until then
        if (restore_valid_i) begin
          next_state.latch = restore_data_i;
          next_state.saved = restore_data_i;
          next_state.fsm = nvl_pkg::NVL_RUN;
        end
      end
      nvl_pkg::NVL_RUN: begin
        if (eval_i) begin
          next_state.latch = eval_next;
        end
        // Any difference from the stored image starts a write
        if (state.latch != state.saved) begin
          next_state.wr_data = state.latch;
          next_state.fsm = nvl_pkg::NVL_SAVE;
        end
      end
      nvl_pkg::NVL_SAVE: begin
        // Latches keep running while the write is outstanding
        if (eval_i) begin
          next_state.latch = eval_next;
        end
        if (nv_ack_i) begin
          next_state.saved = state.wr_data;
          next_state.fsm = nvl_pkg::NVL_RUN;
        end
      end
      default: begin
        next_state.fsm = nvl_pkg::NVL_WAIT_RESTORE;
      end
    endcase
  end

  // =====================================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state.fsm <= nvl_pkg::NVL_WAIT_RESTORE;
      state.latch <= {NUM_LATCHES{`NVL_LATCH_RST_BIT}};
      state.saved <= {NUM_LATCHES{`NVL_LATCH_RST_BIT}};
      state.wr_data <= {NUM_LATCHES{`NVL_LATCH_RST_BIT}};
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // Outputs
  assign latch_on_o = state.latch;
  assign latch_off_o = ~state.latch;
  assign nv_wr_o = (state.fsm == nvl_pkg::NVL_SAVE);
  assign nv_wr_data_o = state.wr_data;
  assign ready_o = (state.fsm != nvl_pkg::NVL_WAIT_RESTORE);

  // =====================================================================
  // Checks on the bank as a whole

  // On and off are always complements
  AST_ON_OFF_COMPLEMENT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    latch_on_o == ~latch_off_o)
    else $error("On and off outputs not complementary");

  // Restored image appears on the outputs one edge later
  AST_RESTORE_LOADS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ready_o && restore_valid_i |=> ready_o && latch_on_o == $past(restore_data_i))
    else $error("Restore image not loaded");

  // Before restore, latches sit at reset value regardless of scans
  AST_NO_EVAL_BEFORE_RESTORE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ready_o && !restore_valid_i |=> $stable(latch_on_o))
    else $error("Latch moved before restore");

  // Write request holds with stable data until acknowledged
  AST_WRITE_HOLDS: assert property (@(posedge clk_i) disable iff (!rstn_i)
    nv_wr_o && !nv_ack_i |=> nv_wr_o && $stable(nv_wr_data_o))
    else $error("Write request dropped before ack");

  // Latch value unlike the stored image starts a write with that value
  // (a restore changes the outputs but matches the image, so no write)
  AST_CHANGE_SAVED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ready_o && !nv_wr_o && (latch_on_o != state.saved)
    |=> nv_wr_o && (nv_wr_data_o == $past(latch_on_o)))
    else $error("Changed state not written");

endmodule : nvl_latch_bank

// *** inc/nvl_consts.svh ***
// Purpose: Named constants of the non-volatile latch bank
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef NVL_CONSTS_SVH
`define NVL_CONSTS_SVH

// =====================================================================
// Bank geometry
`define NVL_NUM_LATCHES 16
`define NVL_NUM_OPERANDS 64

// =====================================================================
// Latch type encoding and reset values
`define NVL_TYPE_RESET_DOM 1'b0
`define NVL_TYPE_SET_DOM 1'b1
`define NVL_LATCH_RST_BIT 1'b0

`endif

// *** inc/nvl_pkg.sv ***
// Purpose: Types of the non-volatile latch bank
// Assumes: nvl_consts.svh gives the bank size
// Notes:   No constants here besides types
`include "nvl_consts.svh"

package nvl_pkg;

  // =====================================================================
  // Storage sequencer states
  typedef enum logic [1:0] {
    NVL_WAIT_RESTORE = 2'b00,
    NVL_RUN = 2'b01,
    NVL_SAVE = 2'b10
  } nvl_fsm_e;

  typedef logic [`NVL_NUM_LATCHES-1:0] nvl_bits_t;

  // =====================================================================
  // Complete state of the bank
  typedef struct packed {
    nvl_fsm_e fsm;
    nvl_bits_t latch;
    nvl_bits_t saved;
    nvl_bits_t wr_data;
  } nvl_state_s;

endpackage : nvl_pkg

// *** logic/nvl_latch_cell.sv ***
// Purpose: Next-state evaluation of one set/reset latch
// Assumes: Inputs already selected from the operand vector
// Notes:   Purely combinational; state lives in the bank
`include "nvl_consts.svh"

module nvl_latch_cell (
  input wire logic type_i,
  input wire logic set_i,
  input wire logic reset_i,
  input wire logic prev_i,
  output logic next_o
);

  // =====================================================================
  // Truth table of one latch
  always_comb begin
    if (set_i && reset_i) begin
      next_o = (type_i == `NVL_TYPE_SET_DOM);
    end else if (set_i) begin
      next_o = 1'b1;
    end else if (reset_i) begin
      next_o = 1'b0;
    end else begin
      next_o = prev_i;
    end
  end

endmodule : nvl_latch_cell

// *** tb/nvl_store_model.sv ***
// Purpose: Non-volatile storage behind the latch bank
// Assumes: Write held until ack; restore offered after reset
// Notes:   Ack comes DLY+1 cycles late to test a slow store
module nvl_store_model #(
  parameter logic [15:0] INIT = 16'hA5C3,
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic nv_wr_i,
  input wire logic [15:0] nv_wr_data_i,
  output logic restore_valid_o,
  output logic [15:0] restore_data_o,
  output logic nv_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] image = INIT;
  int cnt;
  // =====================================================================
  // Image kept across resets; idle data is inverted
  assign restore_data_o = restore_valid_o ? image : ~image;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      restore_valid_o <= 1'b0;
      nv_ack_o <= 1'b0;
      cnt <= 0;
    end else begin
      restore_valid_o <= 1'b1;
      nv_ack_o <= 1'b0;
      if (nv_wr_i && !nv_ack_o) begin
        cnt <= cnt + 1;
        if (cnt == DLY) begin
          nv_ack_o <= 1'b1;
          cnt <= 0;
          image <= nv_wr_data_i;
        end
      end
    end
  end
endmodule : nvl_store_model

// *** tb/tb_nvl_latch_bank.sv ***
// Purpose: Self-checking bench of the latch bank
// Assumes: Storage model restores its image after each reset
// Notes:   Set op of latch i is operand i, reset op is 16+i
module tb_nvl_latch_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [63:0] operand_i = 64'h0;
  logic eval_i = 1'b0;
  logic [15:0] latch_type_i = 16'h5A3C;
  logic [95:0] set_sel_i;
  logic [95:0] reset_sel_i;
  logic rv, ack, wr, rdy;
  logic [15:0] rd, wd, on_o, off_o;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // =====================================================================
  // Clock and timeout
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      close_out();
    end
  end
  nvl_latch_bank nvl_latch_bank_i (.clk_i(clk_i), .rstn_i(rstn_i), .operand_i(operand_i),
    .eval_i(eval_i), .latch_type_i(latch_type_i), .set_sel_i(set_sel_i),
    .reset_sel_i(reset_sel_i), .restore_valid_i(rv), .restore_data_i(rd), .nv_ack_i(ack),
    .nv_wr_o(wr), .nv_wr_data_o(wd), .ready_o(rdy), .latch_on_o(on_o),
    .latch_off_o(off_o));
  nvl_store_model nvl_store_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .nv_wr_i(wr),
    .nv_wr_data_i(wd), .restore_valid_o(rv), .restore_data_o(rd), .nv_ack_o(ack));
  // =====================================================================
  // Tasks
  task automatic close_out();
    $display("mismatches %0d of %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // Ready flag against expectation
  task automatic chk_ready(input logic exp);
    samples_checked = samples_checked + 1;
    if (rdy !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t ready %b exp %b", $time, rdy, exp);
    end
  endtask : chk_ready
  // Wait for a storage write request, then compare its image
  task automatic chk_write(input logic [15:0] exp);
    for (int n = 0; n < 10 && wr !== 1'b1; n++) @(posedge clk_i);
    #1;
    samples_checked = samples_checked + 1;
    if (wr !== 1'b1 || wd !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t write %b data %h exp %h", $time, wr, wd, exp);
    end
  endtask : chk_write
  task automatic chk_bank(input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (on_o !== exp || off_o !== ~exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t on %h off %h exp %h", $time, on_o, off_o, exp);
    end
  endtask : chk_bank
  task automatic eval_op(input logic [15:0] s, input logic [15:0] r);
    @(posedge clk_i);
    operand_i <= {32'h0, r, s};
    eval_i <= 1'b1;
    @(posedge clk_i);
    eval_i <= 1'b0;
    #1;
  endtask : eval_op
  // Reset held for 20 edges, released on an edge, then wait for restore
  task automatic reboot();
    rstn_i <= 1'b0;
    repeat (19) @(posedge clk_i);
    #1;
    chk_bank(16'h0000);
    chk_ready(1'b0);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int n = 0; n < 50 && rdy !== 1'b1; n++) @(posedge clk_i);
    #1;
    chk_ready(1'b1);
  endtask : reboot
  // =====================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      set_sel_i[i*6+:6] = 6'(i);
      reset_sel_i[i*6+:6] = 6'(16 + i);
    end
    reboot();
    chk_bank(16'hA5C3);
    eval_op(16'hFFFF, 16'h0000);
    chk_bank(16'hFFFF);
    chk_write(16'hFFFF);
    eval_op(16'h0000, 16'h00FF);
    chk_bank(16'hFF00);
    eval_op(16'h0000, 16'h0000);
    chk_bank(16'hFF00);
    eval_op(16'hFFFF, 16'hFFFF);
    chk_bank(16'h5A3C);
    eval_op(16'h0F0F, 16'h00FF);
    chk_bank(16'h5F0C);
    repeat (40) @(posedge clk_i);
    reboot();
    chk_bank(16'h5F0C);
    close_out();
  end
endmodule : tb_nvl_latch_bank
